// File: design/fpx_pkg.sv
// Package for the floating-point exception trap decision block
package fpx_pkg;

  // Operation classes presented by the datapath
  typedef enum logic [3:0] {
    FPX_OP_BITS     = 4'h0, // Branch, load, store, copy-sign, conditional move
    FPX_OP_ADD      = 4'h1,
    FPX_OP_SUB      = 4'h2,
    FPX_OP_MUL      = 4'h3,
    FPX_OP_DIV      = 4'h4,
    FPX_OP_CMP_EQ   = 4'h5,
    FPX_OP_CMP_UN   = 4'h6,
    FPX_OP_CMP_LT   = 4'h7,
    FPX_OP_CMP_LE   = 4'h8,
    FPX_OP_CVT_F2I  = 4'h9,
    FPX_OP_CVT_I2F  = 4'ha,
    FPX_OP_CVT_F2F  = 4'hb
  } fpx_op_e;

  // Operand condition flags, per operand
  typedef struct packed {
    logic denormal;
    logic infinity;
    logic quiet_nan;
    logic signaling_nan;
    logic zero;
    logic negative;
  } fpx_opnd_s;

  // Qualifiers carried by the instruction
  typedef struct packed {
    logic underflow_en;
    logic inexact_en;
    logic int_ovf_en;
  } fpx_qual_s;

  // Result conditions from the datapath
  typedef struct packed {
    logic exp_overflow;
    logic exp_underflow;
    logic inexact;
    logic int_overflow;
  } fpx_res_s;

  // One request from the pipeline
  typedef struct packed {
    fpx_op_e op;
    fpx_opnd_s opa;
    fpx_opnd_s opb;
    fpx_qual_s qual;
    fpx_res_s res;
    logic [63:0] result;
  } fpx_req_s;

  // Exception summary bit positions
  localparam int FPX_SUM_W = 6;
  localparam int FPX_SUM_INV = 0;
  localparam int FPX_SUM_DZE = 1;
  localparam int FPX_SUM_OVF = 2;
  localparam int FPX_SUM_UNF = 3;
  localparam int FPX_SUM_INE = 4;
  localparam int FPX_SUM_IOV = 5;

  // Value written on a zeroed underflow: positive zero
  localparam logic [63:0] FPX_POS_ZERO = 64'h0000_0000_0000_0000;
  localparam logic [FPX_SUM_W-1:0] FPX_SUM_RST = 6'h00;

  // Implementation options
  localparam logic FPX_ALT_UNF_TRAP_RST = 1'b0;
  localparam logic FPX_ALT_F2I_TRAP_RST = 1'b0;

  // Answer produced one cycle after a request
  typedef struct packed {
    logic valid;
    logic trap;
    logic [63:0] result;
    logic [FPX_SUM_W-1:0] summary;
    logic input_exc;
  } fpx_rsp_s;

endpackage : fpx_pkg

// File: design/fpx_trap_unit.sv
// Floating-point exception trap decision block
`timescale 1ns/1ps
`default_nettype none
// Function
// - Branches, loads, stores, copy-sign and conditional moves move bits only and never trap.
// - Add, subtract, multiply, divide and float-to-integer and float-to-float conversions trap on denormal, infinite or NaN operands.
// - Opposite-infinity add, zero times infinity, 0/0, inf/inf and nonzero divided by zero trap.
// - Exponent overflow of arithmetic and float-to-float conversion always traps.
// - Underflow without underflow enable delivers positive zero and does not trap.
// - Underflow with underflow enable writes positive zero and traps.
// - Inexact traps only when the instruction enables inexact trapping.
// - Float-to-integer overflow delivers the truncated result and traps only if enabled.
// - Compares trap on denormal and NaN operands but not on infinities.
// - Negative zero is a legal operand and result, never mistaken for a trap cause.
// - Optionally every underflow traps to firmware, which supplies the zero.
// - Optionally float-to-integer overflow always traps, firmware supplying the truncation.
// - A trapped result may be unpredictable; the datapath result is passed through, except that underflow writes positive zero.
module fpx_trap_unit (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic alt_unf_trap,
  input wire logic alt_f2i_trap,
  input wire logic req_valid,
  input wire fpx_pkg::fpx_req_s req,
  output logic rsp_valid,
  output logic rsp_trap,
  output logic [63:0] rsp_result,
  output logic [fpx_pkg::FPX_SUM_W-1:0] rsp_summary,
  output logic [fpx_pkg::FPX_SUM_W-1:0] trap_summary
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  // Everything that persists between cycles lives in this one struct, so a
  // freeze or a reset treats it as a single unit; the reset flops stay outside
  // because they gate that reset
  typedef struct packed {
    fpx_pkg::fpx_rsp_s rsp;
    logic [fpx_pkg::FPX_SUM_W-1:0] sticky_sum;
    logic alt_unf;
    logic alt_f2i;
  } fpx_state_s;

  logic rst_meta_ff;
  logic rst_sync_ff;

  // Two flops so release is synchronous to the core clock; only the second
  // flop is read elsewhere, since the first may still be settling
  // The block leaves reset two edges after rst_b rises, so the first request
  // is taken on the third edge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Classification
  // ----------------------------------------------------------------
  fpx_state_s state_ff;
  fpx_state_s nxt_state;

  logic is_arith;
  logic is_cmp;
  logic is_cvt_in;
  logic a_special;
  logic b_special;
  logic a_nan;
  logic b_nan;
  logic b_used;
  logic invalid_pair;
  logic div_zero;

  // Which classes inspect operands; bit moves are left out entirely
  always_comb begin
    is_arith = (req.op == fpx_pkg::FPX_OP_ADD) || (req.op == fpx_pkg::FPX_OP_SUB) ||
               (req.op == fpx_pkg::FPX_OP_MUL) || (req.op == fpx_pkg::FPX_OP_DIV);
    is_cmp = (req.op == fpx_pkg::FPX_OP_CMP_EQ) || (req.op == fpx_pkg::FPX_OP_CMP_UN) ||
             (req.op == fpx_pkg::FPX_OP_CMP_LT) || (req.op == fpx_pkg::FPX_OP_CMP_LE);
    // Int-to-float has an integer source, so only its output can except
    is_cvt_in = (req.op == fpx_pkg::FPX_OP_CVT_F2I) || (req.op == fpx_pkg::FPX_OP_CVT_F2F);
    a_nan = req.opa.quiet_nan | req.opa.signaling_nan;
    // Operand b carries meaning only for two-operand classes; its flags are
    // left stale by single-operand conversions and must not leak into a summary
    b_used = is_arith | is_cmp;
    // Single-operand conversions use operand a only
    b_nan = is_arith & (req.opb.quiet_nan | req.opb.signaling_nan);
    // Zero flag ignores sign, so -0 behaves as zero and never as special
    a_special = req.opa.denormal | req.opa.infinity | a_nan;
    b_special = is_arith & (req.opb.denormal | req.opb.infinity | b_nan);
  end

  // Invalid pairings and divide by zero
  always_comb begin
    invalid_pair = 1'b0;
    div_zero = 1'b0;
    case (req.op)
      fpx_pkg::FPX_OP_ADD: invalid_pair = req.opa.infinity & req.opb.infinity &
                                          (req.opa.negative ^ req.opb.negative);
      // Same-sign infinities subtracted are the magnitude subtraction of infinities
      fpx_pkg::FPX_OP_SUB: invalid_pair = req.opa.infinity & req.opb.infinity &
                                          (req.opa.negative ~^ req.opb.negative);
      fpx_pkg::FPX_OP_MUL: invalid_pair = (req.opa.zero & req.opb.infinity) |
                                          (req.opa.infinity & req.opb.zero);
      fpx_pkg::FPX_OP_DIV: begin
        invalid_pair = (req.opa.zero & req.opb.zero) | (req.opa.infinity & req.opb.infinity);
        // A zero or NaN dividend is not a divide by zero; a NaN traps as an input anyway
        div_zero = req.opb.zero & ~req.opa.zero & ~a_nan;
      end
      default: begin
        invalid_pair = 1'b0;
        div_zero = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Trap decision and next state
  // ----------------------------------------------------------------
  always_comb begin
    logic in_exc;
    logic ovf;
    logic unf;
    logic ine;
    logic iov;
    logic trap;
    logic [fpx_pkg::FPX_SUM_W-1:0] sum;
    in_exc = 1'b0;
    ovf = 1'b0;
    unf = 1'b0;
    ine = 1'b0;
    iov = 1'b0;
    trap = 1'b0;
    sum = '0;
    nxt_state = state_ff;
    nxt_state.rsp.valid = 1'b0;
    if (req_valid) begin
      if (is_arith || is_cvt_in) begin
        in_exc = a_special | b_special | invalid_pair | div_zero;
      end else if (is_cmp) begin
        // Infinities compare normally
        in_exc = req.opa.denormal | a_nan | req.opb.denormal |
                 req.opb.quiet_nan | req.opb.signaling_nan;
      end
      if (is_arith || req.op == fpx_pkg::FPX_OP_CVT_F2F) begin
        ovf = req.res.exp_overflow;
        unf = req.res.exp_underflow;
      end
      if (is_arith || is_cvt_in || req.op == fpx_pkg::FPX_OP_CVT_I2F) begin
        ine = req.res.inexact;
      end
      iov = (req.op == fpx_pkg::FPX_OP_CVT_F2I) & req.res.int_overflow;
      // Bit moves fall through with every flag clear
      // Overflow is never gated: the handler must always see an infinity being made
      trap = in_exc | ovf |
             (unf & (req.qual.underflow_en | state_ff.alt_unf)) |
             (ine & req.qual.inexact_en) |
             (iov & (req.qual.int_ovf_en | state_ff.alt_f2i));
      // Integer overflow of a conversion also counts as an invalid operation;
      // an integer source has no operand flags worth reading
      sum[fpx_pkg::FPX_SUM_INV] = ((is_arith | is_cmp | is_cvt_in) & req.opa.signaling_nan) |
                                  (b_used & req.opb.signaling_nan) |
                                  invalid_pair | iov;
      sum[fpx_pkg::FPX_SUM_DZE] = div_zero;
      sum[fpx_pkg::FPX_SUM_OVF] = ovf;
      sum[fpx_pkg::FPX_SUM_UNF] = unf;
      sum[fpx_pkg::FPX_SUM_INE] = ine;
      sum[fpx_pkg::FPX_SUM_IOV] = iov;
      nxt_state.rsp.valid = 1'b1;
      nxt_state.rsp.trap = trap;
      nxt_state.rsp.input_exc = in_exc;
      // Only trapped operations report, so a quiet underflow leaves no mark
      nxt_state.rsp.summary = trap ? sum : '0;
      // Underflow yields +0 unless an operand exception is seen, trapping or not; the sign is dropped on purpose
      if (unf && !in_exc) begin
        nxt_state.rsp.result = fpx_pkg::FPX_POS_ZERO;
      end else begin
        // Truncated integer on overflow, or the datapath value; may be junk if trapped
        nxt_state.rsp.result = req.result;
      end
      // Sticky summary of all trapped classes, for the handler to read
      if (trap) begin
        nxt_state.sticky_sum = state_ff.sticky_sum | sum;
      end
    end
    // Options are latched each enabled cycle so they change only between requests
    nxt_state.alt_unf = alt_unf_trap;
    nxt_state.alt_f2i = alt_f2i_trap;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // A low enable holds every field, so a stalled pipeline keeps its answer
  // standing and no request is taken meanwhile
  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      state_ff.rsp <= '0;
      state_ff.sticky_sum <= fpx_pkg::FPX_SUM_RST;
      state_ff.alt_unf <= fpx_pkg::FPX_ALT_UNF_TRAP_RST;
      state_ff.alt_f2i <= fpx_pkg::FPX_ALT_F2I_TRAP_RST;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Outputs straight from flops, so the pipeline sees no decode glitches
  assign rsp_valid = state_ff.rsp.valid;
  assign rsp_trap = state_ff.rsp.trap;
  assign rsp_result = state_ff.rsp.result;
  assign rsp_summary = state_ff.rsp.summary;
  assign trap_summary = state_ff.sticky_sum;

endmodule : fpx_trap_unit
`default_nettype wire

// File: verif/fpx_trap_unit_chk.sv
// Assertion checker for the trap decision block
`timescale 1ns/1ps
`default_nettype none
module fpx_trap_chk (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic alt_unf_trap,
  input wire logic alt_f2i_trap,
  input wire logic req_valid,
  input wire fpx_pkg::fpx_req_s req,
  input wire logic rsp_valid,
  input wire logic rsp_trap,
  input wire logic [63:0] rsp_result,
  input wire logic [5:0] rsp_summary,
  input wire logic [5:0] trap_summary
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // Request decode shared by the properties
  wire logic v = req_valid && clk_en;
  wire logic [3:0] op = req.op;
  wire logic ar = op inside {1, 2, 3, 4, 11};
  wire logic cv = ar || op inside {9, 10};
  // Clean request: no operand exception or option pin, so only the named cause may trap
  sequence tk(c);
    // Options act one cycle late, and a zero divisor traps on its own
    v && c && req.opa[5:2] == 4'h0 && req.opb[5:2] == 4'h0 && !req.opb.zero && !alt_unf_trap &&
      !alt_f2i_trap && !$past(alt_unf_trap) && !$past(alt_f2i_trap) ##1 clk_en;
  endsequence
  a_bits_quiet: assert property (v && op == 4'h0 ##1 clk_en |-> !rsp_trap)
    else $error("bit move trapped");
  a_input_trap: assert property (v && (ar || op == 4'h9) && req.opa[5:2] != 4'h0 ##1 clk_en |-> rsp_trap)
    else $error("operand exception missed");
  a_ovf_trap: assert property (tk(ar && req.res[3]) |-> rsp_trap && rsp_summary[2])
    else $error("overflow missed");
  a_unf_zero: assert property (tk(ar && req.res == 4'h4 && !req.qual[2]) |-> !rsp_trap && rsp_result == 64'h0)
    else $error("quiet underflow wrong");
  a_unf_trap: assert property (tk(ar && req.res == 4'h4 && req.qual[2]) |-> rsp_trap && rsp_result == 64'h0)
    else $error("enabled underflow wrong");
  a_ine_gate: assert property (tk(cv && req.res == 4'h2 && !req.opb.zero) |-> rsp_trap == $past(req.qual[1]))
    else $error("inexact gate wrong");
  a_f2i_trunc: assert property (tk(op == 4'h9 && req.res == 4'h1)
    |-> rsp_trap == $past(req.qual[0]) && rsp_result == $past(req.result)) else $error("int overflow wrong");
  a_sum_sticky: assert property (($past(trap_summary) & ~trap_summary) == 6'h00)
    else $error("summary lost a bit");
  a_sum_quiet: assert property (rsp_valid && !rsp_trap |-> rsp_summary == 6'h00)
    else $error("summary without trap");
  c_trap: cover property (rsp_valid && rsp_trap);
  c_quiet: cover property (rsp_valid && !rsp_trap);
  c_all: cover property (trap_summary == 6'h3f);
endmodule : fpx_trap_chk
bind fpx_trap_unit fpx_trap_chk u_chk (.core_clk, .rst_b, .clk_en, .alt_unf_trap, .alt_f2i_trap, .req_valid,
  .req, .rsp_valid, .rsp_trap, .rsp_result, .rsp_summary, .trap_summary);
`default_nettype wire

// File: verif/fpx_dp_model.sv
// Datapath model that presents requests to the trap block
`timescale 1ns/1ps
`default_nettype none
module fpx_dp_model (
  input wire logic core_clk,
  output logic req_valid,
  output var fpx_pkg::fpx_req_s req
);
  // Quiet at time zero
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  // Held over one sampling edge; back-to-back calls keep valid high
  task automatic send(input fpx_pkg::fpx_req_s r);
    req_valid = 1'b1;
    req = r;
    @(posedge core_clk);
    #1;
  endtask : send
  // Released bus shows the inverse of the last request, so stale data is never trusted
  task automatic idle;
    req_valid = 1'b0;
    req = fpx_pkg::fpx_req_s'(~req);
  endtask : idle
endmodule : fpx_dp_model
`default_nettype wire

// File: verif/tb_fp_exception_trap_logic.sv
// Self-checking bench for the trap decision block
`timescale 1ns/1ps
`default_nettype none
module tb_fp_exception_trap_logic;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic alt_unf_trap = 1'b0;
  logic alt_f2i_trap = 1'b0;
  logic req_valid;
  fpx_pkg::fpx_req_s req;
  logic rsp_valid;
  logic rsp_trap;
  logic [63:0] rsp_result;
  logic [5:0] rsp_summary;
  logic [5:0] trap_summary;
  logic [5:0] acc = 6'h00;
  int bad_count = 0;
  int checks_done = 0;
  // Clock of 4 ns
  always #2 core_clk = ~core_clk;
  fpx_dp_model u_dp (.core_clk, .req_valid, .req);
  fpx_trap_unit dut (.core_clk, .rst_b, .clk_en, .alt_unf_trap, .alt_f2i_trap, .req_valid, .req, .rsp_valid,
    .rsp_trap, .rsp_result, .rsp_summary, .trap_summary);
  // Compare and count
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Payload repeats the fields so each answer is traceable
  function automatic fpx_pkg::fpx_req_s mk(input logic [3:0] o, input logic [5:0] a, input logic [5:0] b,
    input logic [2:0] q, input logic [3:0] r);
    mk = fpx_pkg::fpx_req_s'({o, a, b, q, r, 41'h1_2345_6789, o, a, b, q, r});
  endfunction : mk
  // e: trap, zero result, summary unchecked, summary
  task automatic xp(input fpx_pkg::fpx_req_s r, input logic [8:0] e);
    u_dp.send(r);
    chk("answer", {63'h1, e[8]}, {62'h0, rsp_valid, rsp_trap});
    chk("result", e[7] ? 64'h0 : r.result, rsp_result);
    if (!e[6]) chk("summary", {58'h0, e[5:0]}, {58'h0, rsp_summary});
    acc = acc | e[5:0];
  endtask : xp
  // Bit moves ignore every condition
  task automatic s_bits;
    xp(mk(4'h0, 6'h3f, 6'h3f, 3'h7, 4'hf), 9'h000);
  endtask : s_bits
  // Each operand exception on each arithmetic class and on float-to-integer and float-to-float conversion
  task automatic s_input;
    for (int o = 1; o < 12; o++) begin
      for (int k = 2; k < 6; k++) begin
        if (o < 5 || o == 9 || o == 11) xp(mk(o[3:0], 6'h01 << k, '0, '0, '0), 9'h140);
      end
    end
  endtask : s_input
  // Divide pairings and signed zeros; 0/x is the quiet boundary
  task automatic s_pairs;
    xp(mk(4'h4, 6'h00, 6'h02, '0, '0), 9'h102);
    xp(mk(4'h4, 6'h02, 6'h02, '0, '0), 9'h101);
    xp(mk(4'h4, 6'h02, 6'h00, '0, '0), 9'h000);
    xp(mk(4'h1, 6'h03, 6'h02, '0, '0), 9'h000);
    xp(mk(4'h3, 6'h03, 6'h01, '0, '0), 9'h000);
  endtask : s_pairs
  // Low enable freezes the last answer and ignores the request until released
  task automatic s_hold;
    fpx_pkg::fpx_req_s r0;
    r0 = mk(4'h1, '0, '0, '0, '0);
    xp(r0, 9'h000);
    clk_en = 1'b0;
    u_dp.send(mk(4'h4, 6'h02, 6'h02, '0, '0));
    chk("frozen", 64'h2, {62'h0, rsp_valid, rsp_trap});
    chk("held", r0.result, rsp_result);
    clk_en = 1'b1;
    xp(mk(4'h4, 6'h02, 6'h02, '0, '0), 9'h101);
  endtask : s_hold
  // Result conditions against their enables
  task automatic s_out;
    for (int o = 1; o < 12; o++) begin
      if (o < 5 || o > 8) begin
        xp(mk(o[3:0], '0, '0, 3'h0, 4'h2), 9'h000);
        xp(mk(o[3:0], '0, '0, 3'h2, 4'h2), 9'h110);
        if (o < 9 || o == 11) xp(mk(o[3:0], '0, '0, 3'h0, 4'h8), 9'h104);
      end
    end
    xp(mk(4'h1, '0, '0, 3'h3, 4'h4), 9'h080);
    xp(mk(4'h3, '0, '0, 3'h4, 4'h4), 9'h188);
    xp(mk(4'h9, '0, '0, 3'h6, 4'h1), 9'h000);
    xp(mk(4'h9, '0, '0, 3'h1, 4'h1), 9'h121);
  endtask : s_out
  // Compares pass infinities and trap on the other exceptions
  task automatic s_cmp;
    for (int o = 5; o < 9; o++) begin
      xp(mk(o[3:0], 6'h10, 6'h10, '0, '0), 9'h000);
      for (int k = 2; k < 6; k++) begin
        if (k != 4) xp(mk(o[3:0], '0, 6'h01 << k, '0, '0), 9'h140);
      end
    end
  endtask : s_cmp
  // Option pins are sampled a cycle early, so idle two edges after each change
  task automatic s_alt;
    u_dp.idle();
    alt_unf_trap = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    xp(mk(4'h1, '0, '0, '0, 4'h4), 9'h188);
    u_dp.idle();
    alt_unf_trap = 1'b0;
    alt_f2i_trap = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    xp(mk(4'h9, '0, '0, '0, 4'h1), 9'h121);
    u_dp.idle();
    alt_f2i_trap = 1'b0;
  endtask : s_alt
  // Sticky summary holds every class seen, then a mid-run reset clears it
  task automatic s_reset;
    chk("sticky", {58'h0, acc}, {58'h0, trap_summary});
    rst_b = 1'b0;
    repeat (12) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    xp(mk(4'h1, '0, '0, '0, '0), 9'h000);
    chk("cleared", 64'h0, {58'h0, trap_summary});
  endtask : s_reset
  // Verdict
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    s_bits();
    s_input();
    s_pairs();
    s_hold();
    s_out();
    s_cmp();
    s_alt();
    s_reset();
    summarize();
  end
endmodule : tb_fp_exception_trap_logic
`default_nettype wire
